// ---- core/pls_sequencer.sv ----
// process loop sequencer: unit decode, gain select, output clamp, pre-loop, sleep, bypass
// assumes inputs synchronous to CLK_IN and settings stable between updates
// What this block does
// R1: the unit code decodes 0 percent, 1-4 pressure, 5-6 frequency/speed, 7-10 electrical, 11-12 temperature.
// R2: an active second-gain input selects the alternate proportional gain.
// R3: with loop bypassed by input, loop percent values are given out as hertz.
// R4: the loop output is unipolar and clamped between the lower and upper limits.
// R5: full scale loop output maps to the maximum output frequency.
// R6: a run command accelerates to the pre-loop frequency until feedback exceeds the exit level, then loop runs.
// R7: a nonzero pre-loop delay with feedback held below exit for that delay trips and blocks output.
// R8: output frequency below sleep frequency for the sleep delay stops the drive into sleep.
// R9: wake mode 0 wakes when feedback falls below the wake level.
// R10: wake mode 1 wakes when feedback rises above the wake level.
// R11: wake mode 2 wakes when reference minus feedback exceeds the wake level.
// R12: an input with function 23 on bypasses loop control until it turns off.
// R13: comparisons are made once per update and delay timers restart when their condition drops.
`timescale 1ns/100ps
module pls_sequencer
  import pls_pkg::*;
#(
  parameter int NIN = 5
) (
  // clock and reset
  input  wire logic                  CLK_IN,
  input  wire logic                  RESET_N_IN,
  // control update and run
  input  wire logic                  UPDATE_IN,
  input  wire logic                  RUN_IN,
  input  wire logic                  TRIP_CLEAR_IN,
  // multi-function inputs
  input  wire logic [NIN-1:0]        MF_ACTIVE_IN,
  input  wire logic [NIN*6-1:0]      MF_FUNC_IN,
  // settings
  input  wire pls_cfg_s              CFG_IN,
  input  wire logic [3:0]            PROCESS_UNIT_SELECT_IN,
  input  wire logic [PLS_VW-1:0]     NORMAL_PROP_GAIN_IN,
  input  wire logic [PLS_VW-1:0]     ALTERNATE_PROP_GAIN_IN,
  // process values
  input  wire logic [PLS_VW-1:0]     FEEDBACK_IN,
  input  wire logic [PLS_VW-1:0]     REFERENCE_IN,
  input  wire logic signed [PLS_VW:0] LOOP_RAW_IN,
  input  wire logic [PLS_VW-1:0]     OUTPUT_FREQ_IN,
  // results
  output pls_unit_e                  UNIT_CLASS_OUT,
  output logic [PLS_VW-1:0]          PROP_GAIN_OUT,
  output logic                       GAIN2_ACTIVE_OUT,
  output logic [PLS_VW-1:0]          LOOP_OUTPUT_OUT,
  output logic [PLS_VW-1:0]          FREQ_CMD_OUT,
  output logic                       LOOP_ACTIVE_OUT,
  output logic                       BYPASS_OUT,
  output logic                       SLEEP_OUT,
  output logic                       OUTPUT_BLOCK_OUT,
  output logic                       PRELOOP_FAIL_TRIP_OUT
);
  initial begin
    if (NIN < 1 || NIN > 16) $error("input count out of range");
  end

  // ----------------------------------------
  // unit decode and input functions
  // ----------------------------------------
  // R1 unit class decode
  wire [3:0] u = PROCESS_UNIT_SELECT_IN;
  wire pls_unit_e unit_dec = (u <= PLS_UNIT_PCT_MAX) ? PLS_U_PCT :
                             (u <= PLS_UNIT_PRS_MAX) ? PLS_U_PRS :
                             (u <= PLS_UNIT_FRQ_MAX) ? PLS_U_FRQ :
                             (u <= PLS_UNIT_ELC_MAX) ? PLS_U_ELC :
                             (u <= PLS_UNIT_TMP_MAX) ? PLS_U_TMP : PLS_U_BAD;

  logic [NIN-1:0] hit_gain2;
  logic [NIN-1:0] hit_bypass;
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_mf
      assign hit_gain2[gi]  = MF_ACTIVE_IN[gi] && (MF_FUNC_IN[gi*6 +: 6] == PLS_FN_GAIN2);
      assign hit_bypass[gi] = MF_ACTIVE_IN[gi] && (MF_FUNC_IN[gi*6 +: 6] == PLS_FN_BYPASS);
    end
  endgenerate
  wire gain2  = |hit_gain2;
  wire bypass = |hit_bypass;

  // ----------------------------------------
  // loop output clamp and scale
  // ----------------------------------------
  // R4 unipolar clamp
  wire signed [PLS_VW:0] hi_s = $signed({1'b0, CFG_IN.loop_output_upper_limit});
  wire signed [PLS_VW:0] lo_s = $signed({1'b0, CFG_IN.loop_output_lower_limit});
  wire signed [PLS_VW:0] clamp_s = (LOOP_RAW_IN > hi_s) ? hi_s : (LOOP_RAW_IN < lo_s) ? lo_s : LOOP_RAW_IN;
  wire [PLS_VW-1:0] loop_clamped = clamp_s[PLS_VW] ? '0 : clamp_s[PLS_VW-1:0];
  // R5 full scale to max frequency
  wire [2*PLS_VW-1:0] prod = loop_clamped * CFG_IN.max_output_frequency;
  wire [2*PLS_VW-1:0] quot = prod / {{PLS_VW{1'b0}}, PLS_FULL_SCALE};
  wire [PLS_VW-1:0] loop_hz = quot[PLS_VW-1:0];

  // ----------------------------------------
  // sequencing conditions
  // ----------------------------------------
  wire fb_over_exit = FEEDBACK_IN > CFG_IN.preloop_exit_level;
  wire fb_low_pre   = !fb_over_exit;
  wire low_freq     = OUTPUT_FREQ_IN < CFG_IN.sleep_frequency;
  wire [PLS_VW:0] diff = {1'b0, REFERENCE_IN} - {1'b0, FEEDBACK_IN};
  // R9 R10 R11 wake criteria
  wire wake_below  = (CFG_IN.wake_mode == PLS_WAKE_BELOW) && (FEEDBACK_IN < CFG_IN.wake_level);
  wire wake_above  = (CFG_IN.wake_mode == PLS_WAKE_ABOVE) && (FEEDBACK_IN > CFG_IN.wake_level);
  wire wake_beyond = (CFG_IN.wake_mode == PLS_WAKE_BEYOND) && !diff[PLS_VW] &&
                     (diff[PLS_VW-1:0] > CFG_IN.wake_level);
  wire wake = wake_below || wake_above || wake_beyond;

  pls_state_e state_reg;
  pls_state_e state_next;
  logic       pre_fail;
  logic       sleep_due;

  // R7 pre-loop fail timer
  pls_timer #(.TW(PLS_TW)) u_pre_tmr (
    .CLK_IN     (CLK_IN),
    .RESET_N_IN (RESET_N_IN),
    .upd_in     (UPDATE_IN),
    .cond_in    ((state_reg == PLS_PRE) && fb_low_pre),
    .limit_in   (CFG_IN.preloop_fail_delay),
    .done_out   (pre_fail)
  );

  // R8 sleep delay timer
  pls_timer #(.TW(PLS_TW)) u_slp_tmr (
    .CLK_IN     (CLK_IN),
    .RESET_N_IN (RESET_N_IN),
    .upd_in     (UPDATE_IN),
    .cond_in    ((state_reg == PLS_LOOP) && !bypass && low_freq),
    .limit_in   (CFG_IN.sleep_delay_time),
    .done_out   (sleep_due)
  );

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PLS_IDLE:  if (RUN_IN) state_next = PLS_PRE;
      // R6 pre-loop exit
      PLS_PRE: begin
        if (!RUN_IN) state_next = PLS_IDLE;
        else if (pre_fail) state_next = PLS_TRIP;
        else if (fb_over_exit) state_next = PLS_LOOP;
      end
      // R8 enter sleep
      PLS_LOOP: begin
        if (!RUN_IN) state_next = PLS_IDLE;
        else if (sleep_due) state_next = PLS_SLEEP;
      end
      PLS_SLEEP: begin
        if (!RUN_IN) state_next = PLS_IDLE;
        else if (wake) state_next = PLS_LOOP;
      end
      PLS_TRIP:  if (TRIP_CLEAR_IN) state_next = PLS_IDLE;
      default:   state_next = PLS_IDLE;
    endcase
  end

  // R13 once per update
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) state_reg <= PLS_IDLE;
    else if (UPDATE_IN) state_reg <= state_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic [PLS_VW-1:0] loop_out_reg;
  logic [PLS_VW-1:0] freq_reg;
  logic [PLS_VW-1:0] gain_reg;
  logic              gain2_reg;
  // R12 bypass to general operation
  wire loop_run = (state_reg == PLS_LOOP) && !bypass;
  // R3 percent to hertz when bypassed
  wire [PLS_VW-1:0] freq_next = (state_reg == PLS_PRE) ? CFG_IN.preloop_frequency :
                                (state_reg == PLS_LOOP) ? loop_hz : '0;
  // R2 alternate gain select
  wire [PLS_VW-1:0] gain_next = gain2 ? ALTERNATE_PROP_GAIN_IN : NORMAL_PROP_GAIN_IN;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      loop_out_reg <= '0;
      freq_reg     <= '0;
      gain_reg     <= '0;
      gain2_reg    <= 1'b0;
    end else if (UPDATE_IN) begin
      loop_out_reg <= loop_clamped;
      freq_reg     <= freq_next;
      gain_reg     <= gain_next;
      gain2_reg    <= gain2;
    end
  end

  assign UNIT_CLASS_OUT        = unit_dec;
  assign PROP_GAIN_OUT         = gain_reg;
  assign GAIN2_ACTIVE_OUT      = gain2_reg;
  assign LOOP_OUTPUT_OUT       = loop_out_reg;
  assign FREQ_CMD_OUT          = freq_reg;
  assign LOOP_ACTIVE_OUT       = loop_run;
  assign BYPASS_OUT            = bypass && (state_reg == PLS_LOOP);
  assign SLEEP_OUT             = (state_reg == PLS_SLEEP);
  // R7 block output on trip
  assign OUTPUT_BLOCK_OUT      = (state_reg == PLS_TRIP);
  assign PRELOOP_FAIL_TRIP_OUT = (state_reg == PLS_TRIP);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_unit;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) (u >= 4'h7 && u <= 4'ha) |-> (UNIT_CLASS_OUT == PLS_U_ELC);
  endproperty
  a_unit: assert property (p_unit) else $error("unit decode wrong"); // R1
  property p_gain;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) (UPDATE_IN && gain2)
      |=> (PROP_GAIN_OUT == $past(ALTERNATE_PROP_GAIN_IN));
  endproperty
  a_gain: assert property (p_gain) else $error("alternate gain not used"); // R2
  property p_clamp;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) UPDATE_IN &&
      (CFG_IN.loop_output_lower_limit <= CFG_IN.loop_output_upper_limit)
      |=> (LOOP_OUTPUT_OUT <= $past(CFG_IN.loop_output_upper_limit)) &&
          (LOOP_OUTPUT_OUT >= $past(CFG_IN.loop_output_lower_limit));
  endproperty
  a_clamp: assert property (p_clamp) else $error("loop output outside limits"); // R4
  property p_full;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) (UPDATE_IN && state_reg == PLS_LOOP && loop_clamped == PLS_FULL_SCALE)
      |=> (FREQ_CMD_OUT == $past(CFG_IN.max_output_frequency));
  endproperty
  a_full: assert property (p_full) else $error("full scale not max frequency"); // R5
  property p_pre;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) (UPDATE_IN && state_reg == PLS_PRE && RUN_IN &&
      !pre_fail && fb_over_exit) |=> (state_reg == PLS_LOOP);
  endproperty
  a_pre: assert property (p_pre) else $error("loop not started after exit level"); // R6
  property p_trip;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) (UPDATE_IN && state_reg == PLS_PRE && RUN_IN && pre_fail)
      |=> OUTPUT_BLOCK_OUT && PRELOOP_FAIL_TRIP_OUT;
  endproperty
  a_trip: assert property (p_trip) else $error("pre-loop fail not tripped"); // R7
  property p_sleep;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) (UPDATE_IN && state_reg == PLS_LOOP && RUN_IN && sleep_due)
      |=> SLEEP_OUT;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered"); // R8
  property p_wake;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) (UPDATE_IN && SLEEP_OUT && RUN_IN && wake) |=> (state_reg == PLS_LOOP);
  endproperty
  a_wake: assert property (p_wake) else $error("wake not taken"); // R9
  property p_bypass;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) (UPDATE_IN && state_reg == PLS_LOOP && RUN_IN && bypass)
      |-> !LOOP_ACTIVE_OUT ##1 (state_reg == PLS_LOOP);
  endproperty
  a_bypass: assert property (p_bypass) else $error("loop active while bypassed"); // R12
endmodule : pls_sequencer

// ---- core/pls_pkg.sv ----
// package for the process loop sequencer: widths, codes, states, carriers
// assumes one control clock; times counted in control updates
package pls_pkg;

  // ----------------------------------------
  // widths and codes
  // ----------------------------------------
  localparam int PLS_VW          = 16;           // percent/frequency value width
  localparam int PLS_TW          = 16;           // timer count width
  localparam logic [PLS_VW-1:0] PLS_FULL_SCALE = 16'h03e8;  // 100.0 percent in 0.1 steps
  localparam logic [3:0] PLS_UNIT_PCT_MAX  = 4'h0;
  localparam logic [3:0] PLS_UNIT_PRS_MAX  = 4'h4;
  localparam logic [3:0] PLS_UNIT_FRQ_MAX  = 4'h6;
  localparam logic [3:0] PLS_UNIT_ELC_MAX  = 4'ha;
  localparam logic [3:0] PLS_UNIT_TMP_MAX  = 4'hc;
  localparam logic [1:0] PLS_WAKE_BELOW    = 2'h0;
  localparam logic [1:0] PLS_WAKE_ABOVE    = 2'h1;
  localparam logic [1:0] PLS_WAKE_BEYOND   = 2'h2;
  localparam logic [5:0] PLS_FN_BYPASS     = 6'h17;   // function code 23
  localparam logic [5:0] PLS_FN_GAIN2      = 6'h18;   // second-gain function code
  localparam logic [PLS_TW-1:0] PLS_TMR_RESET = 16'h0000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [4:0] {
    PLS_IDLE  = 5'b00001,
    PLS_PRE   = 5'b00010,
    PLS_LOOP  = 5'b00100,
    PLS_SLEEP = 5'b01000,
    PLS_TRIP  = 5'b10000
  } pls_state_e;

  typedef enum logic [5:0] {
    PLS_U_PCT = 6'b000001,
    PLS_U_PRS = 6'b000010,
    PLS_U_FRQ = 6'b000100,
    PLS_U_ELC = 6'b001000,
    PLS_U_TMP = 6'b010000,
    PLS_U_BAD = 6'b100000
  } pls_unit_e;

  typedef struct packed {
    logic [PLS_VW-1:0] preloop_frequency;
    logic [PLS_VW-1:0] preloop_exit_level;
    logic [PLS_TW-1:0] preloop_fail_delay;
    logic [PLS_TW-1:0] sleep_delay_time;
    logic [PLS_VW-1:0] sleep_frequency;
    logic [PLS_VW-1:0] wake_level;
    logic [1:0]        wake_mode;
    logic [PLS_VW-1:0] loop_output_upper_limit;
    logic [PLS_VW-1:0] loop_output_lower_limit;
    logic [PLS_VW-1:0] max_output_frequency;
  } pls_cfg_s;

endpackage : pls_pkg

// ---- core/pls_timer.sv ----
// condition timer: counts updates while a condition holds, flags when a nonzero limit is reached
// assumes upd_in marks one control update per pulse
`timescale 1ns/100ps
module pls_timer
  import pls_pkg::*;
#(
  parameter int TW = PLS_TW
) (
  // clock and reset
  input  wire logic          CLK_IN,
  input  wire logic          RESET_N_IN,
  // control
  input  wire logic          upd_in,
  input  wire logic          cond_in,
  input  wire logic [TW-1:0] limit_in,
  // result
  output logic               done_out
);
  initial begin
    if (TW < 2) $error("timer width too small");
  end

  logic [TW-1:0] cnt_reg;
  logic [TW-1:0] cnt_next;
  wire           at_lim = (cnt_reg >= limit_in);

  assign cnt_next = !cond_in ? TW'(0) : (at_lim ? cnt_reg : cnt_reg + TW'(1));
  assign done_out = cond_in && at_lim && (limit_in != TW'(0));

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) cnt_reg <= '0;
    else if (upd_in) cnt_reg <= cnt_next;
  end

  // R13 restart on false
  property p_restart;
    @(posedge CLK_IN) disable iff (!RESET_N_IN) (upd_in && !cond_in) |=> (cnt_reg == TW'(0));
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted"); // R13
endmodule : pls_timer

// ---- tb/pls_partner.sv ----
// far side model: drive frequency controller and update strobe source
// assumes one control clock; frequency follows the command one update later
`timescale 1ns/100ps
module pls_partner
  import pls_pkg::*;
#(
  parameter int UPD_DIV = 4
) (
  // clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              RESET_N_IN,
  // frequency command from the sequencer
  input  wire logic [PLS_VW-1:0] FREQ_CMD_IN,
  // strobe and measured frequency
  output logic                   UPDATE_OUT,
  output logic [PLS_VW-1:0]      OUTPUT_FREQ_OUT
);
  // ----------------------------------------
  // update strobe, one pulse per UPD_DIV cycles
  // ----------------------------------------
  int cnt;
  always @(negedge CLK_IN) begin
    cnt        = RESET_N_IN ? (cnt + 1) % UPD_DIV : 0;
    UPDATE_OUT = RESET_N_IN && (cnt == 0);
  end
  // ----------------------------------------
  // controller settles on the command each update
  // ----------------------------------------
  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      OUTPUT_FREQ_OUT <= '0;
    end else if (UPDATE_OUT) begin
      OUTPUT_FREQ_OUT <= FREQ_CMD_IN;
    end
  end
endmodule : pls_partner

// ---- tb/pls_sequencer_tb_top.sv ----
// bench for the process loop sequencer: one task per scenario
// assumes the partner model supplies updates and output frequency
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module pls_sequencer_tb_top;
  import pls_pkg::*;
  logic clk, rst_n, upd, run, clr;
  logic [4:0] mf_act;
  pls_cfg_s cfg;
  logic [3:0] usel;
  logic [PLS_VW-1:0] fb, ref_v, ofreq, lp, fc, pg;
  logic signed [PLS_VW:0] raw;
  pls_unit_e ucls;
  logic g2, la, byp, slp, blk, trp;
  int bad_count, checks, k;
  // ----------------------------------------
  // clock, partner and design
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  pls_partner pls_partner_i (.CLK_IN(clk), .RESET_N_IN(rst_n), .FREQ_CMD_IN(fc),
    .UPDATE_OUT(upd), .OUTPUT_FREQ_OUT(ofreq));
  pls_sequencer pls_sequencer_i (.CLK_IN(clk), .RESET_N_IN(rst_n), .UPDATE_IN(upd),
    .RUN_IN(run), .TRIP_CLEAR_IN(clr), .MF_ACTIVE_IN(mf_act),
    .MF_FUNC_IN({6'h00, 6'h00, PLS_FN_GAIN2, 6'h00, PLS_FN_BYPASS}), .CFG_IN(cfg),
    .PROCESS_UNIT_SELECT_IN(usel), .NORMAL_PROP_GAIN_IN(16'h0011),
    .ALTERNATE_PROP_GAIN_IN(16'h0022), .FEEDBACK_IN(fb), .REFERENCE_IN(ref_v),
    .LOOP_RAW_IN(raw), .OUTPUT_FREQ_IN(ofreq), .UNIT_CLASS_OUT(ucls), .PROP_GAIN_OUT(pg),
    .GAIN2_ACTIVE_OUT(g2), .LOOP_OUTPUT_OUT(lp), .FREQ_CMD_OUT(fc), .LOOP_ACTIVE_OUT(la),
    .BYPASS_OUT(byp), .SLEEP_OUT(slp), .OUTPUT_BLOCK_OUT(blk), .PRELOOP_FAIL_TRIP_OUT(trp));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic upd_wait(input int n);
    repeat (n) begin
      @(posedge upd);
      @(negedge clk);
    end
  endtask : upd_wait
  task automatic conclude;
    $display("counts: checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_units;
    pls_unit_e e;
    for (int c = 0; c < 16; c++) begin
      usel = 4'(c);
      #1;
      e = c == 0 ? PLS_U_PCT : c <= 4 ? PLS_U_PRS : c <= 6 ? PLS_U_FRQ :
          c <= 10 ? PLS_U_ELC : c <= 12 ? PLS_U_TMP : PLS_U_BAD;
      `CHK("unit class", e, ucls)
      @(negedge clk);
    end
    $display("test units done");
  endtask : t_units
  task automatic t_gain;
    mf_act[2] = 1'b1;
    upd_wait(2);
    `CHK("alt gain", 16'h0022, pg)
    `CHK("gain2 flag", 1'b1, g2)
    mf_act[2] = 1'b0;
    upd_wait(2);
    `CHK("normal gain", 16'h0011, pg)
    $display("test gain done");
  endtask : t_gain
  task automatic t_trip;
    cfg.preloop_fail_delay = 16'h0004;
    fb = '0;
    run = 1'b1;
    upd_wait(4);
    `CHK("trip early", 1'b0, trp)
    for (k = 0; k < 10 && trp !== 1'b1; k++) upd_wait(1);
    `CHK("trip", 1'b1, trp)
    `CHK("block", 1'b1, blk)
    run = 1'b0;
    clr = 1'b1;
    upd_wait(2);
    clr = 1'b0;
    `CHK("trip cleared", 1'b0, trp)
    `CHK("unblocked", 1'b0, blk)
    cfg.preloop_fail_delay = '0;
    $display("test trip done");
  endtask : t_trip
  task automatic t_preloop_clamp;
    logic signed [PLS_VW:0] rv[3] = '{-17'sd100, 17'sd500, 17'sd1200};
    logic [PLS_VW-1:0] el[3] = '{16'd50, 16'd500, 16'd1000};
    run = 1'b1;
    upd_wait(4);
    `CHK("preloop freq", cfg.preloop_frequency, fc)
    `CHK("not loop yet", 1'b0, la)
    `CHK("no trip at zero delay", 1'b0, trp)
    fb = 16'd600;
    upd_wait(3);
    `CHK("loop started", 1'b1, la)
    for (int i = 0; i < 3; i++) begin
      raw = rv[i];
      upd_wait(3);
      `CHK("loop out", el[i], lp)
      `CHK("freq cmd", 16'(32'(el[i]) * cfg.max_output_frequency / 1000), fc)
    end
    $display("test preloop and clamp done");
  endtask : t_preloop_clamp
  task automatic t_bypass;
    raw = 17'sd500;
    mf_act[0] = 1'b1;
    upd_wait(3);
    `CHK("bypass", 1'b1, byp)
    `CHK("loop off", 1'b0, la)
    `CHK("hertz out", 16'd3000, fc)
    mf_act[0] = 1'b0;
    upd_wait(3);
    `CHK("loop back", 1'b1, la)
    $display("test bypass done");
  endtask : t_bypass
  task automatic t_sleep;
    logic [PLS_VW-1:0] idle_fb[3] = '{16'd500, 16'd100, 16'd800};
    logic [PLS_VW-1:0] wake_fb[3] = '{16'd100, 16'd500, 16'd100};
    cfg.sleep_delay_time = 16'h0006;
    for (int m = 0; m < 3; m++) begin
      cfg.wake_mode = 2'(m);
      fb = idle_fb[m];
      raw = '0;
      upd_wait(3);
      `CHK("sleep early", 1'b0, slp)
      for (k = 0; k < 20 && slp !== 1'b1; k++) upd_wait(1);
      `CHK("sleep", 1'b1, slp)
      fb = wake_fb[m];
      upd_wait(2);
      `CHK("woken", 1'b0, slp)
      `CHK("loop resumed", 1'b1, la)
    end
    run = 1'b0;
    $display("test sleep done");
  endtask : t_sleep
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    bad_count = 0;
    checks = 0;
    rst_n = 1'b0;
    run = 1'b0;
    clr = 1'b0;
    mf_act = '0;
    usel = '0;
    fb = '0;
    ref_v = 16'd800;
    raw = '0;
    cfg = '{preloop_frequency: 16'd1500, preloop_exit_level: 16'd400, preloop_fail_delay: '0,
      sleep_delay_time: '0, sleep_frequency: 16'd500, wake_level: 16'd300, wake_mode: 2'h0,
      loop_output_upper_limit: 16'd1000, loop_output_lower_limit: 16'd50,
      max_output_frequency: 16'd6000};
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_units();
    t_gain();
    t_trip();
    t_preloop_clamp();
    t_bypass();
    t_sleep();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule : pls_sequencer_tb_top
